// >>> logic/rai_pkg.sv
// remote alarm generator constants and types
// assumes a 25 MHz clock and frame timing pulses from the framer
package rai_pkg;
   // register byte addresses (status is ours)
   localparam logic [11:0] CTRL_ADDR = 12'h108;
   localparam logic [11:0] STAT_ADDR = 12'h10C;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // control field positions
   localparam int RULE_BIT = 7;
   localparam int PULSE_BIT = 6;
   localparam int FMT_LSB = 4;
   // format select codes
   localparam logic [1:0] FMT_OFF = 2'h0;
   localparam logic [1:0] FMT_STD = 2'h1;
   localparam logic [1:0] FMT_JSF = 2'h2;
   localparam logic [1:0] FMT_JESF = 2'h3;
   // data link pattern
   localparam logic [7:0] PAT_REPEAT = 8'hFF;
   localparam logic [15:0] PAT_STD = 16'hFF00;
   localparam logic [15:0] PAT_ONES = 16'hFFFF;
   // hold-off: one second in 125 us frames
   localparam int ONE_SECOND_US = 1000000;
   localparam int FRAME_US = 125;
   localparam int HOLD_FRAMES = ONE_SECOND_US / FRAME_US;
   localparam logic [11:0] UNUSED_LIM = 12'h000;
   // framing modes
   typedef enum logic [1:0] {
      MODE_SF = 2'h0,
      MODE_N = 2'h1,
      MODE_ESF = 2'h2,
      MODE_DIGITAL_DATA = 2'h3
   } rai_mode_t;
   // one-hot alarm states
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_SEND = 3'h2,
      ST_HOLD = 3'h4
   } rai_state_t;
   // frame timing strobes
   typedef struct packed {
      logic frame_start;
      logic dl_slot;
   } rai_timing_t;
   // alarm overrides toward the transmit framer
   typedef struct packed {
      logic bit2_zero;
      logic ybit_zero;
      logic fs12_one;
      logic dl_active;
      logic dl_bit;
   } rai_out_t;
endpackage

// >>> logic/rai_pat_gen.sv
// data link pattern shifter, msb first, one bit per slot
// assumes step pulses one cycle per data link bit slot
`timescale 1ns/100ps
`default_nettype none
module rai_pat_gen (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic load,
   input wire logic ones_only,
   input wire logic step,
   output logic dl_bit,
   output logic pat_done
);
   // shifter state
   typedef struct packed {
      logic [3:0] cnt;
      logic ones;
      logic bit_q;
   } rai_pg_t;
   rai_pg_t pg_ff;
   rai_pg_t nxt_pg;
   logic [15:0] pat;

   // choose the 16-bit word
   assign pat = pg_ff.ones ? rai_pkg::PAT_ONES : rai_pkg::PAT_STD;
   // last bit of a word leaves now: the index has wrapped, lsb waiting
   assign pat_done = ce & step & (pg_ff.cnt == 4'h0);
   assign dl_bit = pg_ff.bit_q;

   // next state
   always_comb begin
      nxt_pg = pg_ff;
      if (load) begin
         // restart on a word boundary; msb preloaded so the first slot never shows a stale bit
         nxt_pg.cnt = 4'h1;
         nxt_pg.ones = ones_only;
         nxt_pg.bit_q = ones_only ? rai_pkg::PAT_ONES[15] : rai_pkg::PAT_STD[15];
      end else if (step) begin
         // bit_q leads: it holds the bit for the coming slot
         nxt_pg.bit_q = pat[~pg_ff.cnt];
         nxt_pg.cnt = pg_ff.cnt + 4'h1;
      end
   end

   // register with freeze
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pg_ff <= '0;
      end else if (ce) begin
         pg_ff <= nxt_pg;
      end
   end
endmodule
`default_nettype wire

// >>> logic/rai_hold_timer.sv
// frame counting hold-off timer
// assumes tick pulses once per transmit frame
`timescale 1ns/100ps
`default_nettype none
module rai_hold_timer #(
   parameter int LIMIT = rai_pkg::HOLD_FRAMES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic start,
   input wire logic tick,
   output logic busy
);
   localparam int W = $clog2(LIMIT + 1);
   // a zero length would never clear busy
   if (LIMIT < 1) begin : g_chk
      $error("LIMIT must be at least 1");
   end
   // timer state
   typedef struct packed {
      logic busy;
      logic [W-1:0] cnt;
   } rai_ht_t;
   rai_ht_t ht_ff;
   rai_ht_t nxt_ht;
   assign busy = ht_ff.busy;

   // restart wins over counting
   always_comb begin
      nxt_ht = ht_ff;
      if (start) begin
         nxt_ht.busy = 1'b1;
         nxt_ht.cnt = '0;
      end else if (tick && ht_ff.busy) begin
         nxt_ht.cnt = ht_ff.cnt + W'(1);
         if (ht_ff.cnt == W'(LIMIT - 1)) begin
            nxt_ht.busy = 1'b0;
         end
      end
   end

   // register with freeze
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ht_ff <= '0;
      end else if (ce) begin
         ht_ff <= nxt_ht;
      end
   end
endmodule
`default_nettype wire

// >>> logic/rai_gen.sv
// transmit remote alarm generator with apb control
// assumes framer timing strobes synchronous to clk
`timescale 1ns/100ps
`default_nettype none
module rai_gen #(
   parameter int HOLD_FRAMES = rai_pkg::HOLD_FRAMES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire rai_pkg::rai_mode_t framing_mode,
   input wire rai_pkg::rai_timing_t timing,
   output rai_pkg::rai_out_t rai_out
);
   // whole block state
   typedef struct packed {
      logic [7:0] ctrl;
      logic en_prev;
      rai_pkg::rai_state_t st;
      logic [7:0] pat_cnt;
      logic [31:0] rdata;
      logic bit2_zero;
      logic ybit_zero;
      logic fs12_one;
      logic dl_active;
   } rai_st_t;
   rai_st_t st_ff;
   rai_st_t nxt_st;

   // address decode, one-hot {status, control}
   function automatic logic [1:0] reg_sel(
      input logic [11:0] a
   );
      reg_sel = {a == rai_pkg::STAT_ADDR,
         a == rai_pkg::CTRL_ADDR};
   endfunction

   logic [1:0] sel; // decoded address
   logic wr_ctrl; // control write at access
   logic en; // pulse enable bit
   logic rise; // enable went high
   logic rule; // gap enforced
   logic [1:0] fmt; // format select
   logic esf; // ESF framing now
   logic hold_busy; // gap timer running
   logic pat_done; // word finished
   logic step; // shift one dl bit
   logic start_evt; // alarm begins
   logic end_evt; // alarm ends
   logic load; // reset the shifter
   logic snd; // next state sends
   logic dl_bit; // shifter output

   // control fields
   assign en = st_ff.ctrl[rai_pkg::PULSE_BIT];
   assign rule = st_ff.ctrl[rai_pkg::RULE_BIT];
   assign fmt = st_ff.ctrl[rai_pkg::FMT_LSB +: 2];
   assign rise = en & ~st_ff.en_prev;
   assign esf = framing_mode == rai_pkg::MODE_ESF;

   // apb slave: zero wait states, frozen by ce
   assign sel = reg_sel(paddr);
   assign pready = ce;
   assign pslverr = psel & penable & ~(|sel);
   assign wr_ctrl = psel & penable & pwrite & sel[0];
   assign prdata = st_ff.rdata;

   // data link bits only while sending ESF
   assign step = timing.dl_slot & esf
      & (st_ff.st == rai_pkg::ST_SEND);

   // dl pattern shifter
   rai_pat_gen u_pat (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .load(load),
      .ones_only(fmt == rai_pkg::FMT_JESF),
      .step(step),
      .dl_bit(dl_bit),
      .pat_done(pat_done)
   );

   // one second gap, counted in frames
   rai_hold_timer #(
      .LIMIT(HOLD_FRAMES)
   ) u_hold (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .start(end_evt),
      .tick(timing.frame_start),
      .busy(hold_busy)
   );

   // outputs from flip-flops, dl_bit gated by the dl_active flop
   assign rai_out = '{
      bit2_zero: st_ff.bit2_zero,
      ybit_zero: st_ff.ybit_zero,
      fs12_one: st_ff.fs12_one,
      dl_active: st_ff.dl_active,
      dl_bit: dl_bit & st_ff.dl_active
   };

   // next state of the whole block
   always_comb begin
      nxt_st = st_ff;
      start_evt = 1'b0;
      end_evt = 1'b0;
      load = 1'b0;
      nxt_st.en_prev = en;
      // software write to control
      if (wr_ctrl) begin
         nxt_st.ctrl = pwdata[7:0];
      end
      // read data latched in setup phase
      if (psel && !penable) begin
         unique case (sel)
            2'h1: nxt_st.rdata = {24'h0, st_ff.ctrl};
            2'h2: nxt_st.rdata = {21'h0, en, hold_busy,
               st_ff.st == rai_pkg::ST_SEND,
               st_ff.pat_cnt};
            default: nxt_st.rdata = 32'h0;
         endcase
      end
      unique case (st_ff.st)
         // wait for a request
         rai_pkg::ST_IDLE: begin
            // ESF waits for format and enable, others for format
            if (fmt != rai_pkg::FMT_OFF
               && (!esf || en)) begin
               start_evt = 1'b1;
               load = 1'b1;
               nxt_st.pat_cnt = 8'h00;
               nxt_st.st = rai_pkg::ST_SEND;
            end
         end
         // alarm on the line
         rai_pkg::ST_SEND: begin
            if (fmt == rai_pkg::FMT_OFF) begin
               end_evt = 1'b1;
            end else if (esf
               && fmt == rai_pkg::FMT_JSF) begin
               // any length, tracks enable
               end_evt = ~en;
            end else if (esf) begin
               if (rise) begin
                  // extend by another 255 words
                  nxt_st.pat_cnt = 8'h00;
               end else if (pat_done
                  && st_ff.pat_cnt != rai_pkg::PAT_REPEAT) begin
                  // saturates while enable stays high
                  nxt_st.pat_cnt = st_ff.pat_cnt + 8'h01;
               end
               // stop only on a word boundary
               if (pat_done && !en && !rise
                  && st_ff.pat_cnt >=
                  rai_pkg::PAT_REPEAT - 8'h01) begin
                  end_evt = 1'b1;
               end
            end
            if (end_evt) begin
               nxt_st.st = rai_pkg::ST_HOLD;
            end
         end
         // gap before the next alarm
         rai_pkg::ST_HOLD: begin
            // gap skipped when not enforced
            if (!rule || !hold_busy) begin
               nxt_st.st = rai_pkg::ST_IDLE;
            end
         end
         default: begin
            // illegal code recovers to idle
            nxt_st.st = rai_pkg::ST_IDLE;
         end
      endcase
      // line overrides follow the next state
      snd = nxt_st.st == rai_pkg::ST_SEND;
      nxt_st.bit2_zero = snd && fmt[0]
         && (framing_mode == rai_pkg::MODE_SF
         || framing_mode == rai_pkg::MODE_N);
      nxt_st.ybit_zero = snd && fmt != rai_pkg::FMT_OFF
         && framing_mode
         == rai_pkg::MODE_DIGITAL_DATA;
      nxt_st.fs12_one = snd && fmt == rai_pkg::FMT_JSF
         && framing_mode == rai_pkg::MODE_SF;
      nxt_st.dl_active = snd && esf;
   end

   // register with freeze
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_ff <= '{
            ctrl: rai_pkg::CTRL_RST,
            en_prev: 1'b0,
            st: rai_pkg::ST_IDLE,
            pat_cnt: 8'h00,
            rdata: 32'h0,
            bit2_zero: 1'b0,
            ybit_zero: 1'b0,
            fs12_one: 1'b0,
            dl_active: 1'b0
         };
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   // checks, all in the clk domain
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   logic sending; // helper for checks
   assign sending = st_ff.st == rai_pkg::ST_SEND;

   // format 00 silences every override
   property p_off_silent;
      (ce && fmt == rai_pkg::FMT_OFF) |=>
         !(rai_out.bit2_zero || rai_out.ybit_zero
         || rai_out.fs12_one || rai_out.dl_active);
   endproperty
   a_off_silent: assert property (p_off_silent)
      else $error("alarm sent with format off");

   // bit 2 only in SF/N with 01 or 11
   property p_bit2;
      rai_out.bit2_zero |->
         $past(fmt[0]) && !$past(esf)
         && $past(framing_mode)
         != rai_pkg::MODE_DIGITAL_DATA;
   endproperty
   a_bit2: assert property (p_bit2)
      else $error("bit 2 forced in wrong mode");

   // Y-bit only in digital data framing
   property p_ybit;
      rai_out.ybit_zero |-> $past(framing_mode)
         == rai_pkg::MODE_DIGITAL_DATA && sending;
   endproperty
   a_ybit: assert property (p_ybit)
      else $error("Y-bit forced in wrong mode");

   // frame 12 Fs only for SF with 10
   property p_fs12;
      rai_out.fs12_one |->
         $past(fmt) == rai_pkg::FMT_JSF
         && $past(framing_mode) == rai_pkg::MODE_SF;
   endproperty
   a_fs12: assert property (p_fs12)
      else $error("Fs override in wrong mode");

   // no restart while the gap runs
   property p_gap;
      (st_ff.st == rai_pkg::ST_HOLD && rule
         && hold_busy) |=> !sending;
   endproperty
   a_gap: assert property (p_gap)
      else $error("alarm restarted inside gap");

   // a counted alarm ends only after 255 words
   property p_count_end;
      (end_evt && esf && fmt[0]) |->
         st_ff.pat_cnt >= rai_pkg::PAT_REPEAT - 8'h01
         && pat_done;
   endproperty
   a_count_end: assert property (p_count_end)
      else $error("alarm ended before 255 words");

   // held enable never ends an ESF alarm
   property p_hold_on;
      (sending && esf && en
         && fmt != rai_pkg::FMT_OFF) |-> !end_evt;
   endproperty
   a_hold_on: assert property (p_hold_on)
      else $error("alarm ended with enable high");

   // new enable pulse clears the counter
   property p_restart;
      (ce && sending && esf && rise
         && fmt != rai_pkg::FMT_OFF
         && fmt != rai_pkg::FMT_JSF) |=>
         st_ff.pat_cnt == 8'h00 && sending;
   endproperty
   a_restart: assert property (p_restart)
      else $error("enable pulse did not restart count");

   // format 10 in ESF stops with enable
   property p_follow;
      (ce && sending && esf && !en
         && fmt == rai_pkg::FMT_JSF) |=>
         st_ff.st == rai_pkg::ST_HOLD
         ##1 !rai_out.dl_active;
   endproperty
   a_follow: assert property (p_follow)
      else $error("format 10 alarm outlived enable");

   // an ESF alarm never starts without the pulse enable
   property p_esf_start;
      (ce && st_ff.st == rai_pkg::ST_IDLE && esf && !en)
         |=> !sending;
   endproperty
   a_esf_start: assert property (p_esf_start)
      else $error("ESF alarm started without enable");

   // an all-ones alarm opens with a one on the link
   property p_ones;
      (ce && start_evt && esf && fmt == rai_pkg::FMT_JESF)
         |=> rai_out.dl_active && rai_out.dl_bit;
   endproperty
   a_ones: assert property (p_ones)
      else $error("all-ones alarm opened with a zero");

   // main scenarios
   c_esf_done: cover property (end_evt && esf && fmt[0]);
   c_extend: cover property (sending && esf && rise);
   c_gap: cover property (st_ff.st == rai_pkg::ST_HOLD
      && rule && hold_busy);
   c_jsf: cover property (rai_out.fs12_one);
endmodule
`default_nettype wire

// >>> tb/rai_far_end.sv
// far end model: line timing source and data link receiver
// assumes it shares one clock with the alarm generator
`timescale 1ns/100ps
`default_nettype none
module rai_far_end (
   input wire logic clk,
   input wire logic clr,
   input wire rai_pkg::rai_out_t rai_out,
   output rai_pkg::rai_timing_t timing,
   output logic [15:0] slots,
   output logic [15:0] zeros
);
   logic [3:0] phase = 4'h0; // free running line phase
   // strobes idle until the first edge
   initial timing = 2'h0;
   // frame every 16 cycles, data link slot every 2 cycles
   always @(posedge clk) begin
      phase <= phase + 4'h1;
      timing.frame_start <= (phase == 4'hF);
      timing.dl_slot <= phase[0];
   end
   // tally alarm slots and zero bits seen on the link
   always @(posedge clk) begin
      if (clr) begin
         slots <= 16'h0000;
         zeros <= 16'h0000;
      end else if (timing.dl_slot && rai_out.dl_active) begin
         slots <= slots + 16'h0001;
         zeros <= zeros + {15'h0000, ~rai_out.dl_bit};
      end
   end
endmodule
`default_nettype wire

// >>> tb/rai_gen_test.sv
// self-checking bench for the remote alarm generator
// assumes the far end model supplies frame and link timing
`timescale 1ns/100ps
`default_nettype none
module rai_gen_test;
   localparam int HOLD = 4; // short hold-off keeps the run brief
   localparam int WORDS = 255 * 16; // link slots in a full alarm
   localparam logic [11:0] CTRL = rai_pkg::CTRL_ADDR;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic clr = 1'b1; // clears the far end tallies
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic [31:0] q; // last read data
   logic pready;
   logic pslverr;
   logic err; // last error response
   rai_pkg::rai_mode_t mode = rai_pkg::MODE_SF;
   rai_pkg::rai_timing_t timing;
   rai_pkg::rai_out_t rout;
   logic [15:0] slots;
   logic [15:0] zeros;
   int failures = 0;
   int num_checks = 0;

   // 25 MHz clock
   always #20 clk = ~clk;

   rai_gen #(.HOLD_FRAMES(HOLD)) dut (.clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .framing_mode(mode), .timing(timing),
      .rai_out(rout));
   rai_far_end far (.clk(clk), .clr(clr), .rai_out(rout), .timing(timing), .slots(slots),
      .zeros(zeros));

   task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
      end
   endtask

   task automatic ticks(input int n);
      repeat (n) @(posedge clk);
   endtask

   // one apb transfer, held until pready at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // no wait-state count assumed; only the watchdog ends a stall
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic clear();
      clr <= 1'b1;
      ticks(1);
      clr <= 1'b0;
   endtask

   // bounded wait for the link alarm to reach a level
   task automatic wait_dl(input logic lvl, input int lim);
      int n;
      n = 0;
      while (rout.dl_active !== lvl && n < lim) begin
         @(posedge clk);
         n++;
      end
      check("dl_active", 32'(rout.dl_active), 32'(lvl));
   endtask

   // overrides packed as bit2, ybit, fs12, link
   function automatic logic [31:0] ovr();
      return {28'h0000000, rout.bit2_zero, rout.ybit_zero, rout.fs12_one, rout.dl_active};
   endfunction

   // expected override for a non-link mode and format
   function automatic logic [31:0] exp_ovr(int m, int f);
      if (m == 3) return 32'h4;
      if (f == 2) return (m == 0) ? 32'h2 : 32'h0;
      return 32'h8;
   endfunction

   task automatic conclude();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // watchdog well beyond the expected run
   initial begin
      ticks(60000);
      failures++;
      conclude();
   end

   initial begin
      ticks(20);
      rst_b <= 1'b1;
      clr <= 1'b0;
      ticks(1);
      // register default, unmapped place, stalled bus
      apb(1'b0, CTRL, 32'h0);
      check("ctrl reset", q, 32'(rai_pkg::CTRL_RST));
      apb(1'b0, 12'h100, 32'h0);
      check("unmapped err", 32'(err), 32'h1);
      ce <= 1'b0;
      ticks(1);
      check("pready", 32'(pready), 32'h0);
      ce <= 1'b1;
      // every format in the channel-based modes, gap rule off
      for (int m = 0; m < 4; m++) begin
         if (m == 2) continue;
         mode <= rai_pkg::rai_mode_t'(m);
         for (int f = 1; f < 4; f++) begin
            wr(CTRL, 32'(f) << 4);
            ticks(2);
            check("overrides", ovr(), exp_ovr(m, f));
            wr(CTRL, 32'h0);
            ticks(2);
            check("idle", ovr(), 32'h0);
         end
      end
      // link mode: enable without a format sends nothing
      mode <= rai_pkg::MODE_ESF;
      wr(CTRL, 32'h40);
      ticks(10);
      check("no alarm", ovr(), 32'h0);
      // short enable still gives a full alarm
      wr(CTRL, 32'hD0);
      wr(CTRL, 32'h90);
      apb(1'b0, CTRL, 32'h0);
      check("ctrl", q, 32'h90);
      wait_dl(1'b0, 20000);
      check("slots", 32'(slots), 32'(WORDS));
      check("zeros", 32'(zeros), 32'(WORDS / 2));
      // a request inside the hold-off must wait
      wr(CTRL, 32'hD0);
      ticks(20);
      check("held off", ovr(), 32'h0);
      wait_dl(1'b1, 200);
      // held enable keeps the alarm past 255 words
      ticks(WORDS * 2 + 100);
      check("long", ovr(), 32'h1);
      apb(1'b0, rai_pkg::STAT_ADDR, 32'h0);
      check("status", q, 32'h000005FF);
      wr(CTRL, 32'h90);
      wait_dl(1'b0, 40);
      // second pulse mid-alarm restarts the count
      ticks(100);
      clear();
      wr(CTRL, 32'hD0);
      wr(CTRL, 32'h90);
      ticks(4000);
      wr(CTRL, 32'hD0);
      wr(CTRL, 32'h90);
      wait_dl(1'b0, 20000);
      check("extended", 32'(slots >= WORDS + 1900), 32'h1);
      // format 10 follows the enable exactly
      ticks(100);
      wr(CTRL, 32'hE0);
      wait_dl(1'b1, 20);
      ticks(50);
      wr(CTRL, 32'hA0);
      ticks(2);
      check("follow", ovr(), 32'h0);
      // format 11 sends all ones, gap rule off
      ticks(100);
      clear();
      wr(CTRL, 32'h70);
      wr(CTRL, 32'h30);
      wait_dl(1'b0, 20000);
      check("ones slots", 32'(slots), 32'(WORDS));
      check("ones zeros", 32'(zeros), 32'h0);
      wr(CTRL, 32'h70);
      ticks(2);
      check("no gap", ovr(), 32'h1);
      // mid-run reset drops the alarm and the control bits
      rst_b <= 1'b0;
      ticks(20);
      rst_b <= 1'b1;
      ticks(1);
      check("reset ovr", ovr(), 32'h0);
      apb(1'b0, CTRL, 32'h0);
      check("reset ctrl", q, 32'(rai_pkg::CTRL_RST));
      conclude();
   end
endmodule
`default_nettype wire
